// ==== rtl/rclk_pkg.sv ====
/*
 * Package for the reference clock output gating block: port count, strap
 * and request levels, and the grouped pin struct.
 * Assumes one 50 MHz system clock and pins synchronous to it.
 */
package rclk_pkg;
	// ==========================================================
	// Geometry and levels
	localparam int RCLK_NUM_OUT = 4;
	localparam int RCLK_UP_IDX = 0;
	localparam int RCLK_CTRL_WIDTH = 8;
	localparam logic [7:0] RCLK_CTRL_RESET = 8'h00;
	localparam logic RCLK_STRAP_PD = 1'b1;
	localparam logic RCLK_REQ_ACTIVE = 1'b0;

	// ==========================================================
	// Open-drain request pin: input level, driven value, enable low = drive.
	typedef struct packed {
		logic level;
		logic drive;
		logic oeN;
	} rclk_od_pin_t;

	typedef enum logic [2:0] {
		RCLK_ST_BYPASS = 3'b001,
		RCLK_ST_GATING = 3'b010,
		RCLK_ST_STARTUP = 3'b100
	} rclk_state_t;
endpackage

// ==== rtl/rclk_out_gate.sv ====
/*
 * One reference clock output gate: the enable is the AND of the buffer
 * enable, the configured control bit, the request pin and the port status.
 * Assumes all inputs are synchronous to sys_clk.
 */
module rclk_out_gate (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Gating terms
	input wire logic bufEnable,
	input wire logic ctrlEnable,
	input wire logic clockRequestN,
	input wire logic portStatusNeedsClk,
	// Result
	output logic outEnable
);
	import rclk_pkg::*;

	// Registered so the output never glitches on request edges.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			outEnable <= 1'b0;
		end else begin
			outEnable <= bufEnable && ctrlEnable && portStatusNeedsClk
				&& (clockRequestN == RCLK_REQ_ACTIVE);
		end
	end

	a_gate_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
		(bufEnable && ctrlEnable && portStatusNeedsClk && !clockRequestN)
		|=> outEnable)
		else $error("gate did not open when all terms asked");
	a_gate_release: assert property (@(posedge sys_clk) disable iff (!rstn)
		clockRequestN |=> !outEnable)
		else $error("gate stayed open with request released");
endmodule

// ==== rtl/rclk_gating_top.sv ====
/*
 * Reference clock output gating for a four-output buffer in a four-port
 * switch. Merges downstream clock requests onto the upstream request line.
 * Assumes the board pulls every request line high and the strap is static.
 */

module rclk_gating_top #(
	parameter int NUM_OUT = rclk_pkg::RCLK_NUM_OUT,
	parameter int CTRL_WIDTH = rclk_pkg::RCLK_CTRL_WIDTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Strap and configuration
	input wire logic clockBufferPowerdownStrap,
	input wire logic [rclk_pkg::RCLK_CTRL_WIDTH-1:0] clockBufferCtrl,
	input wire logic [rclk_pkg::RCLK_NUM_OUT-1:0] portClockStatus,
	// Request pins
	input wire logic [rclk_pkg::RCLK_NUM_OUT-1:1] clockRequestN,
	input wire logic upClockRequestLevel,
	output logic upClockRequestDrive,
	output logic upClockRequestOeN,
	// Clock outputs
	output logic [rclk_pkg::RCLK_NUM_OUT-1:0] bufferedRefclkOutEn,
	output logic bufferEnable,
	output logic coreRefclkFromBuffer
);
	import rclk_pkg::*;

	// ==========================================================
	// Strap capture and buffer mode
	rclk_state_t state_reg;
	logic strap_reg;
	logic anyDownReq;
	logic [RCLK_NUM_OUT-1:0] reqLevels;
	rclk_od_pin_t upPin;

	// A request line asks for its clock when someone pulls it to the active level.
	function automatic logic lineAsks(input logic lineN);
		return lineN == RCLK_REQ_ACTIVE;
	endfunction

	// The strap is caught after reset release, never loaded under reset.
	// It is a board level, so the extra flop guards against a slow power-up edge;
	// the price is a lag of two cycles on every mode change.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= RCLK_ST_STARTUP;
			strap_reg <= RCLK_STRAP_PD;
		end else begin
			strap_reg <= clockBufferPowerdownStrap;
			case (state_reg)
				RCLK_ST_STARTUP: begin
					// The strap flop still holds its reset value here, so the buffer
					// stays off until a real strap sample has been taken.
					state_reg <= RCLK_ST_BYPASS;
				end
				RCLK_ST_GATING, RCLK_ST_BYPASS: begin
					if (strap_reg == RCLK_STRAP_PD) begin
						state_reg <= RCLK_ST_BYPASS;
					end else begin
						state_reg <= RCLK_ST_GATING;
					end
				end
				default: begin
					state_reg <= RCLK_ST_STARTUP;
				end
			endcase
		end
	end

	assign bufferEnable = (state_reg == RCLK_ST_GATING);
	// In bypass the core must take its own external pair.
	assign coreRefclkFromBuffer = bufferEnable;

	// ==========================================================
	// Upstream request merge, open drain
	assign anyDownReq = |(~clockRequestN);
	// Registering the enable costs a cycle but keeps a glitch on one downstream
	// pin from pulsing the line that is shared with the root.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			upClockRequestOeN <= 1'b1;
		end else begin
			upClockRequestOeN <= !anyDownReq;
		end
	end
	// Open drain: the pin value is always low, only the enable moves.
	assign upPin = '{level: upClockRequestLevel, drive: 1'b0, oeN: upClockRequestOeN};
	assign upClockRequestDrive = upPin.drive;

	// ==========================================================
	// Per-output gates
	// Output 0 follows the wired level, so a downstream request reaches it one
	// cycle after line 0 falls: two cycles in all.
	// Bits 4 to 7 of the control field are spare and ignored.
	assign reqLevels = {clockRequestN, upPin.level};
	genvar gi;
	generate
		for (gi = 0; gi < RCLK_NUM_OUT; gi++) begin : gGate
			// Output 0 feeds the switch core, the rest the downstream ports.
			rclk_out_gate uGate (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.bufEnable(bufferEnable),
				.ctrlEnable(!clockBufferCtrl[gi]),
				.clockRequestN(reqLevels[gi]),
				.portStatusNeedsClk(portClockStatus[gi]),
				.outEnable(bufferedRefclkOutEn[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Checks
	// Assertions watch what this block drives; the line 0 level belongs to the
	// board, so none of them predicts it.
	a_merge_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
		anyDownReq |=> !upClockRequestOeN)
		else $error("upstream request not pulled low");
	a_merge_release: assert property (@(posedge sys_clk) disable iff (!rstn)
		(&clockRequestN) |=> upClockRequestOeN)
		else $error("upstream request held low with all released");
	a_drive_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		!upClockRequestOeN |-> !upClockRequestDrive)
		else $error("upstream request driven high");
	a_strap_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		(clockBufferPowerdownStrap == RCLK_STRAP_PD) [*2] |=> !bufferEnable)
		else $error("buffer enabled with strap high");
	a_strap_on: assert property (@(posedge sys_clk) disable iff (!rstn)
		(clockBufferPowerdownStrap != RCLK_STRAP_PD) [*3] |-> bufferEnable)
		else $error("buffer disabled with strap low");
	a_up_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		upClockRequestLevel |=> !bufferedRefclkOutEn[0])
		else $error("output 0 running with line 0 high");
	a_ctrl_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		clockBufferCtrl[1] |=> !bufferedRefclkOutEn[1])
		else $error("output 1 running while switched off");
	a_down_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		clockRequestN[3] |=> !bufferedRefclkOutEn[3])
		else $error("output 3 running with request released");
	a_bypass_core: assert property (@(posedge sys_clk) disable iff (!rstn)
		!bufferEnable |=> (bufferedRefclkOutEn == '0))
		else $error("output running with buffer disabled");

	a_core_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
		coreRefclkFromBuffer == bufferEnable)
		else $error("core clock source disagrees with buffer mode");
	a_startup_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		(state_reg == RCLK_ST_STARTUP) |=> !bufferEnable)
		else $error("buffer enabled before the strap was sampled");
	a_state_onehot: assert property (@(posedge sys_clk) disable iff (!rstn)
		$onehot(state_reg))
		else $error("mode state lost its one-hot code");
	a_down_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		!upClockRequestOeN |-> $past(anyDownReq))
		else $error("upstream request pulled low with no downstream request");

	// Mode checks on the sampled strap; only a_mode_off covers the startup state.
	a_mode_on: assert property (@(posedge sys_clk) disable iff (!rstn)
		((state_reg != RCLK_ST_STARTUP) && (strap_reg != RCLK_STRAP_PD)) |=> bufferEnable)
		else $error("buffer stayed off with sampled strap low");
	a_mode_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		(strap_reg == RCLK_STRAP_PD) |=> !bufferEnable)
		else $error("buffer turned on with sampled strap high");
	a_mode_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		((state_reg == RCLK_ST_BYPASS) && (strap_reg == RCLK_STRAP_PD))
		|=> (state_reg == RCLK_ST_BYPASS))
		else $error("bypass mode left with sampled strap high");

	c_down_run: cover property (@(posedge sys_clk) disable iff (!rstn)
		bufferedRefclkOutEn[1] ##1 !bufferedRefclkOutEn[1]);
	c_up_merge: cover property (@(posedge sys_clk) disable iff (!rstn)
		!upClockRequestOeN ##1 upClockRequestOeN);
	c_bypass: cover property (@(posedge sys_clk) disable iff (!rstn)
		state_reg == RCLK_ST_BYPASS);
	c_strap_off: cover property (@(posedge sys_clk) disable iff (!rstn)
		bufferEnable ##1 !bufferEnable);
	c_out0_root: cover property (@(posedge sys_clk) disable iff (!rstn)
		bufferedRefclkOutEn[RCLK_UP_IDX] && upPin.oeN);

	// ==========================================================
	// Per-output checks
	// The same checks for every output pair, each against its own line.
	generate
		for (gi = 0; gi < RCLK_NUM_OUT; gi++) begin : gCheck
			a_ctrl_each: assert property (@(posedge sys_clk) disable iff (!rstn)
				clockBufferCtrl[gi] |=> !bufferedRefclkOutEn[gi])
				else $error("output running while its control bit is set");

			a_status_each: assert property (@(posedge sys_clk) disable iff (!rstn)
				!portClockStatus[gi] |=> !bufferedRefclkOutEn[gi])
				else $error("output running without port clock status");

			// Output 0 is judged on the line level, not on the downstream requests.
			a_req_start: assert property (@(posedge sys_clk) disable iff (!rstn)
				(bufferEnable && !clockBufferCtrl[gi] && portClockStatus[gi]
				&& lineAsks(reqLevels[gi])) |=> bufferedRefclkOutEn[gi])
				else $error("requested output did not start");

			a_req_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
				!lineAsks(reqLevels[gi]) |=> !bufferedRefclkOutEn[gi])
				else $error("output running with its request line released");

			a_buf_each: assert property (@(posedge sys_clk) disable iff (!rstn)
				!bufferEnable |=> !bufferedRefclkOutEn[gi])
				else $error("output running while the buffer is off");
		end
	endgenerate
endmodule

// ==== dv/rclk_link_partner.sv ====
/*
 * Far side of the request pins: endpoints on lines 1 to 3, root on line 0.
 * Assumes board pull-ups on every request line and level-only behaviour.
 */
module rclk_link_partner (
	// Far party requests
	input wire logic [3:1] endpointReqN,
	input wire logic rootWantsClk,
	// Device side of line 0
	input wire logic upDrive,
	input wire logic upOeN,
	// Wired lines
	output logic [3:1] downReqN,
	output logic upLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// An endpoint that releases its line lets the pull-up win.
	assign downReqN = endpointReqN;
	// The root pulls line 0 only while it has traffic, else releases it.
	assign upLevel = (upOeN ? 1'b1 : upDrive) & ~rootWantsClk;
endmodule

// ==== dv/tb_rclk_gating_top.sv ====
/*
 * Self-checking bench for the output gating block with a random pin sweep.
 * Assumes the partner model resolves the wired request lines.
 */
`define CHK(nm, ex, got) begin tests_run++; if ((ex) !== (got)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_rclk_gating_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rclk_pkg::*;
	typedef struct packed {logic [3:0] en; logic oeN; logic drv; logic bufOn;} rclk_exp_t;
	logic sys_clk = 1'b0, rstn = 1'b0, strap = 1'b0, rootReq = 1'b0, sampleNow = 1'b0;
	logic [7:0] ctrl = 8'h00;
	logic [3:0] status = 4'h0;
	logic [3:1] epReqN = 3'h7, reqN;
	logic level, drv, oeN, bufOn, coreSel;
	logic [3:0] outEn;
	int bad_count = 0, tests_run = 0, seed = 24;
	rclk_exp_t expQ[$];
	rclk_exp_t got;
	initial forever #10 sys_clk = ~sys_clk;
	rclk_gating_top u_rclk_gating_top (.sys_clk(sys_clk), .rstn(rstn),
		.clockBufferPowerdownStrap(strap), .clockBufferCtrl(ctrl), .portClockStatus(status),
		.clockRequestN(reqN), .upClockRequestLevel(level), .upClockRequestDrive(drv),
		.upClockRequestOeN(oeN), .bufferedRefclkOutEn(outEn), .bufferEnable(bufOn),
		.coreRefclkFromBuffer(coreSel));
	rclk_link_partner u_rclk_link_partner (.endpointReqN(epReqN), .rootWantsClk(rootReq),
		.upDrive(drv), .upOeN(oeN), .downReqN(reqN), .upLevel(level));
	// ==========================================================
	// Checking
	always @(posedge sampleNow) begin
		got = expQ.pop_front();
		`CHK("outEn", got.en, outEn)
		`CHK("oeN", got.oeN, oeN)
		`CHK("drive", got.drv, drv)
		`CHK("bufOn", got.bufOn, bufOn)
		`CHK("coreSel", got.bufOn, coreSel)
	end
	// ==========================================================
	// Stimulus
	// The hold of four cycles covers the slowest path, the strap mode.
	task automatic apply(input logic s, input logic [7:0] c, input logic [3:0] st,
		input logic [3:1] r, input logic rt);
		rclk_exp_t e;
		strap = s;
		ctrl = c;
		status = st;
		epReqN = r;
		rootReq = rt;
		repeat (4) @(negedge sys_clk);
		e.oeN = &r;
		e.drv = 1'b0;
		e.bufOn = ~s;
		e.en[0] = ~s & ~c[0] & st[0] & (rt | ~&r);
		for (int n = 1; n < 4; n++) e.en[n] = ~s & ~c[n] & st[n] & ~r[n];
		expQ.push_back(e);
		sampleNow = 1'b1;
		@(negedge sys_clk);
		sampleNow = 1'b0;
	endtask
	// A reset in mid-run must drop every output to its idle level at once.
	task automatic reset_check();
		rclk_exp_t e;
		rstn = 1'b0;
		@(negedge sys_clk);
		e = '0;
		e.oeN = 1'b1;
		expQ.push_back(e);
		sampleNow = 1'b1;
		@(negedge sys_clk);
		sampleNow = 1'b0;
		rstn = 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (3) @(negedge sys_clk);
		apply(1'b0, 8'h00, 4'hF, 3'h7, 1'b0);
		apply(1'b0, 8'h00, 4'hF, 3'h7, 1'b1);
		apply(1'b1, 8'h00, 4'hF, 3'h0, 1'b1);
		for (int i = 0; i < 80; i++) begin
			if (i == 40) reset_check();
			apply(($random(seed) & 3) == 0, 8'($random(seed)), 4'($random(seed)),
				3'($random(seed)), 1'($random(seed)));
		end
		stop_test();
	end
	initial begin
		#50000;
		bad_count++;
		stop_test();
	end
endmodule
